// ===== hdl/tcb_cfg.svh
// register offsets, field positions, reset values and counts of the timer
`ifndef TCB_CFG_SVH
`define TCB_CFG_SVH

// documented register offsets (byte addresses)
`define TCB_OFF_CTRL1     8'h00
`define TCB_OFF_COUNT     8'h24
`define TCB_OFF_PRESCALE  8'h28
`define TCB_OFF_RELOAD    8'h2c
`define TCB_OFF_CHAN1     8'h34
`define TCB_OFF_CHAN2     8'h38
`define TCB_OFF_CHAN3     8'h3c
`define TCB_OFF_CHAN4     8'h40
`define TCB_OFF_BURSTCTL  8'h48
`define TCB_OFF_BURSTPORT 8'h4c

// extra registers for channel setup and capture queue
`define TCB_OFF_CHANCFG   8'h50
`define TCB_OFF_CAPDATA   8'h54
`define TCB_OFF_CAPSTAT   8'h58

// reset values
`define TCB_RST_COUNT     16'h0000
`define TCB_RST_PRESCALE  16'h0000
`define TCB_RST_RELOAD    16'hffff
`define TCB_RST_CHAN      16'h0000
`define TCB_RST_BURSTCTL  16'h0000
`define TCB_RST_CHANCFG   16'h0000

// burst control fields
`define TCB_BASE_LSB      0
`define TCB_LEN_LSB       8
`define TCB_BURST_MASK    16'h1f1f

// channel setup fields: output mode [3:0], preload [7:4], run [8]
`define TCB_CFG_MODE_LSB  0
`define TCB_CFG_PREL_LSB  4
`define TCB_CFG_RUN_BIT   8
`define TCB_CFG_MASK      16'h01ff

// capture queue shape
`define TCB_CAP_WIDTH     18
`define TCB_CAP_DEPTH     32

// ahb encodings
`define TCB_SIZE_BYTE     3'h0
`define TCB_SIZE_HALF     3'h1

`endif

// ===== hdl/tcb_pkg.sv
// types shared by the timer core
package tcb_pkg;
    // bus data phase tracking
    typedef enum {TCB_IDLE, TCB_DATA} tcb_bus_t;
    typedef logic [15:0] tcb_half_t;
endpackage

// ===== hdl/tcb_timer.sv
// timer counting core with compare channels, burst port and capture queue
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "tcb_cfg.svh"

//************************************************************
// capture queue
//************************************************************
module tcb_fifo #(
    parameter int WIDTH = `TCB_CAP_WIDTH,
    parameter int DEPTH = `TCB_CAP_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             inValid,
    output      logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    output      logic             outValid,
    input  wire logic             outReady,
    output      logic [WIDTH-1:0] outData,
    output      logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_ff;
    logic [PW-1:0]    rdPtr_ff;
    logic [PW:0]      count_ff;
    wire              doPush;
    wire              doPop;

    // full and empty straight from the occupancy count
    assign inReady  = (count_ff != (PW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData  = mem[rdPtr_ff];
    assign level    = count_ff;
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // storage has no reset; only pointers matter
    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    // pointer and occupancy update
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= doPush ? wrPtr_ff + 1'b1 : wrPtr_ff;
            rdPtr_ff <= doPop ? rdPtr_ff + 1'b1 : rdPtr_ff;
            count_ff <= count_ff + (PW+1)'(doPush) - (PW+1)'(doPop);
        end
    end
endmodule

//************************************************************
// timer core
//************************************************************
// What this block does
// - counter steps once per prescale_value plus one input clocks.
// - reload_limit resets to ffff; zero limit keeps the counter stopped.
// - input channel value holds counter latched at latest capture edge.
// - output channel compares its value with counter to drive compare out.
// - preload off: written channel value reaches compare at once.
// - preload on: written value waits in a stage until update event.
// - channels two to four behave like channel one at own offsets.
// - five-bit base offset picks first burst register from control one.
// - burst length field plus one gives transfers, one to thirty-two.
// - burst port access redirects to control one plus base plus index.
// - byte and halfword bursts touch the same number of registers.
// - burst port at 4c; target address is (base plus index) times four.
module tcb_timer (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output      logic        hreadyout,
    output      logic        hresp,
    output      logic [31:0] hrdata,
    input  wire logic [3:0]  chanCaptureIn,
    output      logic [3:0]  chanCompareOut,
    output      logic        updateEvent
);
    //********************************************************
    // state
    //********************************************************
    tcb_pkg::tcb_bus_t  busState_ff;
    logic [7:0]         effAddr_ff;
    logic [1:0]         lane_ff;
    logic               isWrite_ff;
    logic               isByte_ff;
    logic               isHalf_ff;
    logic               isBurst_ff;
    logic               hreadyout_ff;
    logic [31:0]        hrdata_ff;
    tcb_pkg::tcb_half_t count_ff;
    tcb_pkg::tcb_half_t prescale_ff;
    tcb_pkg::tcb_half_t pscCount_ff;
    tcb_pkg::tcb_half_t reload_ff;
    tcb_pkg::tcb_half_t burstCtl_ff;
    tcb_pkg::tcb_half_t chanCfg_ff;
    tcb_pkg::tcb_half_t chanVal_ff [4];
    tcb_pkg::tcb_half_t chanAct_ff [4];
    logic [4:0]         burstIdx_ff;
    logic [3:0]         capSyncA_ff;
    logic [3:0]         capSyncB_ff;
    logic [3:0]         capPrev_ff;
    logic [3:0]         capPend_ff;
    logic [3:0]         cmpOut_ff;
    logic               updateEvent_ff;

    //********************************************************
    // helpers
    //********************************************************
    // merge a bus write into a 16-bit register
    function automatic tcb_pkg::tcb_half_t mergeWrite(
        input tcb_pkg::tcb_half_t oldVal,
        input logic [31:0]        data,
        input logic               isByte,
        input logic               isHalf,
        input logic               isBurst,
        input logic [1:0]         lane
    );
        tcb_pkg::tcb_half_t res;
        res = oldVal;
        if (isByte && isBurst) begin
            // a byte burst fills the low byte of each target register
            res[7:0] = data[{lane, 3'b000} +: 8];
        end else if (isByte) begin
            if (lane == 2'd0) res[7:0] = data[7:0];
            if (lane == 2'd1) res[15:8] = data[15:8];
        end else if (isHalf && lane[1]) begin
            res = oldVal;
        end else begin
            res = data[15:0];
        end
        return res;
    endfunction

    //********************************************************
    // bus address phase and burst redirect
    //********************************************************
    wire        take      = hsel && htrans[1] && hready;
    wire        hitBurst  = (haddr[7:0] == `TCB_OFF_BURSTPORT);
    wire [4:0]  burstBase = burstCtl_ff[`TCB_BASE_LSB +: 5];
    wire [4:0]  burstLen  = burstCtl_ff[`TCB_LEN_LSB +: 5];
    // target byte address (base plus index) times four
    wire [7:0]  burstAddr = {1'b0, ({2'b00, burstBase} +
                                     {2'b00, burstIdx_ff})} << 2;
    wire [7:0]  effAddr   = hitBurst ? `TCB_OFF_CTRL1 + burstAddr
                                     : haddr[7:0];
    wire        burstLast = (burstIdx_ff == burstLen);
    wire        dataPhase = (busState_ff == tcb_pkg::TCB_DATA);
    wire        wrPhase   = dataPhase && isWrite_ff;
    wire        rdPhase   = dataPhase && !isWrite_ff;

    // phase machine: every transfer gets one wait state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busState_ff  <= tcb_pkg::TCB_IDLE;
            hreadyout_ff <= 1'b1;
        end else begin
            case (busState_ff)
                tcb_pkg::TCB_IDLE: begin
                    if (take) begin
                        busState_ff  <= tcb_pkg::TCB_DATA;
                        hreadyout_ff <= 1'b0;
                    end
                end
                tcb_pkg::TCB_DATA: begin
                    busState_ff  <= tcb_pkg::TCB_IDLE;
                    hreadyout_ff <= 1'b1;
                end
                default: begin
                    busState_ff  <= tcb_pkg::TCB_IDLE;
                    hreadyout_ff <= 1'b1;
                end
            endcase
        end
    end

    // latch the decoded address phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            effAddr_ff <= 8'h00;
            lane_ff    <= 2'h0;
            isWrite_ff <= 1'b0;
            isByte_ff  <= 1'b0;
            isHalf_ff  <= 1'b0;
            isBurst_ff <= 1'b0;
        end else if (take) begin
            effAddr_ff <= effAddr;
            lane_ff    <= haddr[1:0];
            isWrite_ff <= hwrite;
            isByte_ff  <= (hsize == `TCB_SIZE_BYTE);
            isHalf_ff  <= (hsize == `TCB_SIZE_HALF);
            isBurst_ff <= hitBurst;
        end
    end

    // running index steps once per port access and wraps
    // wrap after length plus one transfers
    // the index steps the same way for byte and halfword
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            burstIdx_ff <= 5'h00;
        end else if (wrPhase && effAddr_ff == `TCB_OFF_BURSTCTL) begin
            burstIdx_ff <= 5'h00;
        end else if (take && hitBurst) begin
            burstIdx_ff <= burstLast ? 5'h00 : burstIdx_ff + 5'h01;
        end
    end

    //********************************************************
    // write decode
    //********************************************************
    wire wrCount    = wrPhase && effAddr_ff == `TCB_OFF_COUNT;
    wire wrPrescale = wrPhase && effAddr_ff == `TCB_OFF_PRESCALE;
    wire wrReload   = wrPhase && effAddr_ff == `TCB_OFF_RELOAD;
    wire wrBurstCtl = wrPhase && effAddr_ff == `TCB_OFF_BURSTCTL;
    wire wrChanCfg  = wrPhase && effAddr_ff == `TCB_OFF_CHANCFG;
    wire [3:0] outMode  = chanCfg_ff[`TCB_CFG_MODE_LSB +: 4];
    wire [3:0] preload  = chanCfg_ff[`TCB_CFG_PREL_LSB +: 4];
    wire       runOn    = chanCfg_ff[`TCB_CFG_RUN_BIT];
    // each channel sits on its own word offset
    wire [3:0] wrChan;
    assign wrChan[0] = wrPhase && effAddr_ff == `TCB_OFF_CHAN1;
    assign wrChan[1] = wrPhase && effAddr_ff == `TCB_OFF_CHAN2;
    assign wrChan[2] = wrPhase && effAddr_ff == `TCB_OFF_CHAN3;
    assign wrChan[3] = wrPhase && effAddr_ff == `TCB_OFF_CHAN4;

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prescale_ff <= `TCB_RST_PRESCALE;
            // limit comes up at all ones
            reload_ff   <= `TCB_RST_RELOAD;
            burstCtl_ff <= `TCB_RST_BURSTCTL;
            chanCfg_ff  <= `TCB_RST_CHANCFG;
        end else begin
            if (wrPrescale) prescale_ff <= mergeWrite(prescale_ff, hwdata,
                isByte_ff, isHalf_ff, isBurst_ff, lane_ff);
            if (wrReload) reload_ff <= mergeWrite(reload_ff, hwdata,
                isByte_ff, isHalf_ff, isBurst_ff, lane_ff);
            if (wrBurstCtl) burstCtl_ff <= mergeWrite(burstCtl_ff, hwdata,
                isByte_ff, isHalf_ff, isBurst_ff, lane_ff)
                & `TCB_BURST_MASK;
            if (wrChanCfg) chanCfg_ff <= mergeWrite(chanCfg_ff, hwdata,
                isByte_ff, isHalf_ff, isBurst_ff, lane_ff)
                & `TCB_CFG_MASK;
        end
    end

    //********************************************************
    // prescaler and counter
    //********************************************************
    // zero limit halts both prescaler and counter
    wire running   = runOn && (reload_ff != 16'h0000);
    // one tick per prescale_value plus one input clocks
    wire tick      = running && (pscCount_ff >= prescale_ff);
    wire atLimit   = (count_ff == reload_ff);
    // update event at the wrapping tick
    wire updNow    = tick && atLimit;

    // prescale divider restarts after each tick
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pscCount_ff <= 16'h0000;
        end else if (!running || tick) begin
            pscCount_ff <= 16'h0000;
        end else begin
            pscCount_ff <= pscCount_ff + 16'h0001;
        end
    end

    // a software write to the counter beats a tick
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_ff       <= `TCB_RST_COUNT;
            updateEvent_ff <= 1'b0;
        end else begin
            updateEvent_ff <= updNow;
            if (wrCount) begin
                count_ff <= mergeWrite(count_ff, hwdata,
                    isByte_ff, isHalf_ff, isBurst_ff, lane_ff);
            end else if (updNow) begin
                // wrap to zero past the limit
                count_ff <= 16'h0000;
            end else if (tick) begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    //********************************************************
    // capture inputs
    //********************************************************
    // first stage only feeds the second; edges seen past the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capSyncA_ff <= 4'h0;
            capSyncB_ff <= 4'h0;
            capPrev_ff  <= 4'h0;
        end else begin
            capSyncA_ff <= chanCaptureIn;
            capSyncB_ff <= capSyncA_ff;
            capPrev_ff  <= capSyncB_ff;
        end
    end

    wire [3:0] capEdge = capSyncB_ff & ~capPrev_ff & ~outMode;

    // queue push: lowest pending channel first, stalls while full
    logic [1:0]  pushChan;
    logic        pushValid;
    wire         pushReady;
    wire         popValid;
    wire [17:0]  popData;
    wire [5:0]   capLevel;
    wire         popNow = rdPhase && effAddr_ff == `TCB_OFF_CAPDATA;

    always_comb begin
        pushChan  = 2'd0;
        pushValid = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            if (capPend_ff[i]) begin
                pushChan  = 2'(i);
                pushValid = 1'b1;
            end
        end
    end

    wire [3:0] pushed = (pushValid && pushReady) ? (4'h1 << pushChan)
                                                 : 4'h0;

    // a new edge wins over the push that clears it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capPend_ff <= 4'h0;
        end else begin
            capPend_ff <= (capPend_ff & ~pushed) | capEdge;
        end
    end

    tcb_fifo #(
        .WIDTH (`TCB_CAP_WIDTH),
        .DEPTH (`TCB_CAP_DEPTH)
    ) u_capq (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   ({pushChan, chanVal_ff[pushChan]}),
        .outValid (popValid),
        .outReady (popNow),
        .outData  (popData),
        .level    (capLevel)
    );

    //********************************************************
    // channel value, compare stage and outputs
    //********************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                chanVal_ff[i] <= `TCB_RST_CHAN;
                chanAct_ff[i] <= `TCB_RST_CHAN;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (capEdge[i]) begin
                    chanVal_ff[i] <= count_ff;
                end else if (wrChan[i]) begin
                    chanVal_ff[i] <= mergeWrite(chanVal_ff[i], hwdata,
                        isByte_ff, isHalf_ff, isBurst_ff, lane_ff);
                end
                // no preload, a write reaches compare at once
                if (wrChan[i] && !preload[i]) begin
                    chanAct_ff[i] <= mergeWrite(chanVal_ff[i], hwdata,
                        isByte_ff, isHalf_ff, isBurst_ff, lane_ff);
                // preloaded value moves over on update event
                end else if (updNow && preload[i]) begin
                    chanAct_ff[i] <= chanVal_ff[i];
                end
            end
        end
    end

    // output high while counter below active compare value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmpOut_ff <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cmpOut_ff[i] <= outMode[i] && (count_ff < chanAct_ff[i]);
            end
        end
    end

    //********************************************************
    // read mux
    //********************************************************
    logic [15:0] rdHalf;
    logic [31:0] rdWord;
    always_comb begin
        rdHalf = 16'h0000;
        rdWord = 32'h0000_0000;
        case (effAddr_ff)
            `TCB_OFF_COUNT:    rdHalf = count_ff;
            `TCB_OFF_PRESCALE: rdHalf = prescale_ff;
            `TCB_OFF_RELOAD:   rdHalf = reload_ff;
            `TCB_OFF_CHAN1:    rdHalf = chanVal_ff[0];
            `TCB_OFF_CHAN2:    rdHalf = chanVal_ff[1];
            `TCB_OFF_CHAN3:    rdHalf = chanVal_ff[2];
            `TCB_OFF_CHAN4:    rdHalf = chanVal_ff[3];
            `TCB_OFF_BURSTCTL: rdHalf = burstCtl_ff;
            `TCB_OFF_CHANCFG:  rdHalf = chanCfg_ff;
            default:           rdHalf = 16'h0000;
        endcase
        rdWord = {16'h0000, rdHalf};
        if (effAddr_ff == `TCB_OFF_CAPDATA) begin
            rdWord = popValid ? {14'h0000, popData} : 32'h0000_0000;
        end else if (effAddr_ff == `TCB_OFF_CAPSTAT) begin
            rdWord = {11'h000, burstIdx_ff, 8'h00, capLevel,
                      !pushReady, !popValid};
        end else if (isByte_ff && isBurst_ff) begin
            // byte burst: low byte repeated on all four lanes
            rdWord = {4{rdHalf[7:0]}};
        end
    end

    // read data registered in the single wait cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rdPhase) begin
            hrdata_ff <= rdWord;
        end
    end

    assign hreadyout      = hreadyout_ff;
    assign hresp          = 1'b0;
    assign hrdata         = hrdata_ff;
    assign chanCompareOut = cmpOut_ff;
    assign updateEvent    = updateEvent_ff;
endmodule

// ===== verif/tcb_timer_assertions.sv
// port checks for the timer core, bound to its top module
`timescale 1ns/1ps
//****************************************
// bus and event checks
//****************************************
module tcb_timer_assertions (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0]  chanCompareOut,
    input wire logic        updateEvent
);
    // one domain, so clock and reset are stated once
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // an address phase the slave accepts
    wire logic taken;
    assign taken = hsel && htrans[1] && hready;

    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay)
        else $error("error response seen");
    property p_wait; taken |=> !hreadyout ##1 hreadyout; endproperty
    a_wait: assert property (p_wait)
        else $error("transfer not answered after one wait state");
    property p_cause; $fell(hreadyout) |-> $past(taken); endproperty
    a_cause: assert property (p_cause)
        else $error("wait state without a transfer");
    property p_idle; hreadyout && !taken |=> hreadyout; endproperty
    a_idle: assert property (p_idle)
        else $error("ready dropped while bus idle");
    property p_low; !hreadyout |-> $past(hreadyout) ##1 hreadyout; endproperty
    a_low: assert property (p_low)
        else $error("wait state longer than one cycle");
    // guard on reset: a one-edge reset may clear read data
    property p_hold;
        hreadyout && $past(hreadyout) && !$past(rst) |-> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data changed outside a read");
    property p_reset;
        $past(rst) |-> hreadyout && hrdata == 32'h0
            && chanCompareOut == 4'h0 && !updateEvent;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not at reset values");
    property p_pulse; updateEvent |=> !updateEvent; endproperty
    a_pulse: assert property (p_pulse)
        else $error("update event longer than one cycle");
endmodule

bind tcb_timer tcb_timer_assertions u_chk (.clk_sys, .rst, .hsel, .htrans,
    .hready, .hreadyout, .hresp, .hrdata, .chanCompareOut, .updateEvent);

// ===== verif/tcb_ahb_master.sv
// bus master model standing in for software and the dma engine
`timescale 1ns/1ps
//****************************************
// single-transfer bus master
//****************************************
module tcb_ahb_master (
    input  wire logic        clk_sys,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output      logic        hsel,
    output      logic [31:0] haddr,
    output      logic [1:0]  htrans,
    output      logic        hwrite,
    output      logic [2:0]  hsize,
    output      logic [31:0] hwdata
);
    // bus idle from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // one whole transfer per call, width set by the caller
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [2:0] z, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= z;
        // no fixed latency assumed: wait for ready each phase
        do @(posedge clk_sys); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (!hready);
        q = hrdata;
    endtask
endmodule

// ===== verif/test_timer_count_compare_dma_burst.sv
// self-checking bench for the timer counting core
`timescale 1ns/1ps
`define CK(g, e) begin nCompared++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
//****************************************
// bench top
//****************************************
module test_timer_count_compare_dma_burst;
    logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, updateEvent;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  chanCaptureIn, chanCompareOut;
    logic [31:0] haddr, hwdata, hrdata, r, s;
    logic [7:0]  offs [8] = '{8'h24, 8'h28, 8'h2c, 8'h34, 8'h38, 8'h3c,
                              8'h40, 8'h48};
    int          mismatches = 0;
    int          nCompared = 0;
    int          i, k;

    tcb_timer DUT (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .chanCaptureIn, .chanCompareOut, .updateEvent);
    tcb_ahb_master m (.clk_sys, .hready(hreadyout), .hrdata, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata);

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        m.xfer(1'b1, a, 3'h2, d, r);
    endtask
    task automatic rd(input logic [7:0] a);
        m.xfer(1'b0, a, 3'h2, 32'h0, r);
    endtask
    // one rising edge on the chosen capture pins
    task automatic pulse(input logic [3:0] p);
        chanCaptureIn <= p;
        cyc(4);
        chanCaptureIn <= 4'h0;
        cyc(4);
    endtask
    // cycles to the next update pulse, bounded
    task automatic waitUpd;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (!updateEvent && k < 200);
    endtask

    task automatic testRegs;
        for (i = 0; i < 8; i++) begin
            rd(offs[i]);
            `CK(r, (i == 2) ? 32'hffff : 32'h0)
            wr(offs[i], 32'hffffffff);
            rd(offs[i]);
            `CK(r, (i == 7) ? 32'h1f1f : 32'hffff)
        end
        wr(8'h44, 32'hffff);
        rd(8'h44);
        `CK(r, 32'h0)
        $display("register test done");
    endtask

    task automatic testCount;
        wr(8'h28, 32'h2);
        wr(8'h2c, 32'h4);
        wr(8'h24, 32'h0);
        wr(8'h50, 32'h100);
        waitUpd();
        waitUpd();
        `CK(k, 15)
        wr(8'h2c, 32'h0);
        rd(8'h24);
        s = r;
        cyc(20);
        rd(8'h24);
        `CK(r, s)
        wr(8'h28, 32'h0);
        $display("count test done");
    endtask

    task automatic testCompare;
        // all four as outputs; three and four still compare against ffff
        wr(8'h50, 32'hf);
        wr(8'h24, 32'ha);
        wr(8'h38, 32'h14);
        wr(8'h34, 32'h5);
        cyc(2);
        `CK(chanCompareOut, 4'b1110)
        wr(8'h34, 32'h14);
        cyc(2);
        `CK(chanCompareOut, 4'b1111)
        wr(8'h50, 32'h23);
        wr(8'h38, 32'h0);
        cyc(2);
        `CK(chanCompareOut[1], 1'b1)
        wr(8'h2c, 32'ha);
        wr(8'h50, 32'h123);
        waitUpd();
        cyc(2);
        `CK(chanCompareOut[1], 1'b0)
        wr(8'h50, 32'h0);
        $display("compare test done");
    endtask

    task automatic testBurst;
        wr(8'h24, 32'h33);
        wr(8'h28, 32'h55);
        wr(8'h48, 32'h109);
        for (i = 0; i < 3; i++) begin
            rd(8'h4c);
            `CK(r, (i == 1) ? 32'h55 : 32'h33)
        end
        wr(8'h48, 32'h9);
        m.xfer(1'b0, 8'h4c, 3'h0, 32'h0, r);
        `CK(r, 32'h33333333)
        m.xfer(1'b1, 8'h4c, 3'h0, 32'h12345678, r);
        rd(8'h24);
        `CK(r, 32'h78)
        wr(8'h48, 32'h30d);
        for (i = 1; i < 5; i++) begin
            wr(8'h4c, 32'h11 * i);
        end
        for (i = 1; i < 5; i++) begin
            rd(8'h30 + 8'(4 * i));
            `CK(r, 32'h11 * i)
        end
        wr(8'h48, 32'h1109);
        for (i = 1; i < 19; i++) begin
            rd(8'h4c);
            rd(8'h58);
            `CK(r[20:16], 5'(i % 18))
        end
        $display("burst test done");
    endtask

    task automatic testCapture;
        wr(8'h24, 32'h77);
        pulse(4'h9);
        rd(8'h34);
        `CK(r, 32'h77)
        rd(8'h54);
        `CK(r, 32'h77)
        rd(8'h54);
        `CK(r, 32'h30077)
        for (i = 0; i < 32; i++) begin
            pulse(4'h1);
        end
        rd(8'h58);
        `CK(r[7:0], 8'h82)
        for (i = 0; i < 32; i++) begin
            rd(8'h54);
        end
        rd(8'h58);
        `CK(r[7:0], 8'h01)
        $display("capture test done");
    endtask

    task automatic finish_test;
        $display("compared %0d, mismatched %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ten cycles of reset, then the scenarios in turn
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        chanCaptureIn = 4'h0;
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        testRegs();
        testCount();
        testCompare();
        testBurst();
        testCapture();
        finish_test();
    end
    // run takes about 750 cycles; cut a hang well beyond that
    initial begin
        #40000;
        mismatches++;
        finish_test();
    end
endmodule
